//--- tmb_timer.v
// Two-channel capture/compare timer on a 16-bit up-counter.
// Assumes a one-cycle register port with read data one cycle later, and
// pins that come from outside the clock domain.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tmb_timer #(
    parameter CW = 16
) (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Register port.
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // Pins.
    input wire ext_count_clock_pin,
    input wire chan0_pin_in,
    input wire chan1_pin_in,
    output reg chan0_pin_out,
    output reg chan1_pin_out,
    output wire chan0_pin_oe_n,
    output wire chan1_pin_oe_n,
    // Interrupt requests.
    output wire wrap_irq,
    output wire chan0_irq,
    output wire chan1_irq
);
    // Tap n of the divider ticks every 2^n bus cycles, n = 0..6.
    reg [5:0] pre_r;
    reg [CW-1:0] cnt_r;
    reg [CW-1:0] lim_r;
    reg [7:0] tsc_r;
    reg [7:0] csc0_r;
    reg [7:0] csc1_r;
    reg [CW-1:0] val0_r;
    reg [CW-1:0] val1_r;
    reg [7:0] cnt_lo_latch_r;
    reg [1:0] ext_s_r;
    reg ext_d_r;
    reg [1:0] in0_s_r;
    reg [1:0] in1_s_r;
    reg in0_d_r;
    reg in1_d_r;
    reg act1_r;
    reg pend_r;
    reg pend_sel_r;
    reg tick;
    wire [2:0] ps = tsc_r[2:0];
    wire halt = tsc_r[`TMB_B_HALT];
    wire link = csc0_r[`TMB_B_LINK];
    wire at_lim = (cnt_r == lim_r);
    wire wrap_ev = tick & at_lim;
    wire [CW-1:0] cmp0 = (link & act1_r) ? val1_r : val0_r;
    wire ext_rise = ext_s_r[1] & ~ext_d_r;
    wire [CW-1:0] cap_val = cnt_r + `TMB_SYNC_DELAY - 16'h0001;

    function is_out;
        input [7:0] sc;
        begin
            is_out = sc[`TMB_B_MSA] | sc[`TMB_B_LINK];
        end
    endfunction

    // Edge select: 01 rising, 10 falling, 11 either.
    function edge_hit;
        input [7:0] sc;
        input now;
        input was;
        begin
            edge_hit = (sc[`TMB_B_ELSA] & now & ~was) |
                (sc[`TMB_B_ELSB] & ~now & was);
        end
    endfunction

    // Compare action: 01 toggle, 10 clear, 11 set, 00 pin not driven.
    function cmp_act;
        input [7:0] sc;
        input pin;
        begin
            case ({sc[`TMB_B_ELSB], sc[`TMB_B_ELSA]})
                2'b01: cmp_act = ~pin;
                2'b10: cmp_act = 1'b0;
                2'b11: cmp_act = 1'b1;
                default: cmp_act = pin;
            endcase
        end
    endfunction

    always @* begin
        case (ps)
            3'h0: tick = 1'b1;
            3'h1: tick = pre_r[0];
            3'h2: tick = &pre_r[1:0];
            3'h3: tick = &pre_r[2:0];
            3'h4: tick = &pre_r[3:0];
            3'h5: tick = &pre_r[4:0];
            3'h6: tick = &pre_r[5:0];
            default: tick = ext_rise;
        endcase
        if (halt) begin
            tick = 1'b0;
        end
    end

    // Two-flop synchronisers; only the second stage is examined.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_s_r <= 2'b00;
            ext_d_r <= 1'b0;
        end else begin
            ext_s_r <= {ext_s_r[0], ext_count_clock_pin};
            ext_d_r <= ext_s_r[1];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in0_s_r <= 2'b00;
            in0_d_r <= 1'b0;
        end else begin
            in0_s_r <= {in0_s_r[0], chan0_pin_in};
            in0_d_r <= in0_s_r[1];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in1_s_r <= 2'b00;
            in1_d_r <= 1'b0;
        end else begin
            in1_s_r <= {in1_s_r[0], chan1_pin_in};
            in1_d_r <= in1_s_r[1];
        end
    end

    wire cap0 = ~is_out(csc0_r) &
        edge_hit(csc0_r, in0_s_r[1], in0_d_r);
    wire cap1 = ~link & ~is_out(csc1_r) &
        edge_hit(csc1_r, in1_s_r[1], in1_d_r);
    wire m0 = tick & is_out(csc0_r) & (cnt_r == cmp0);
    wire m1 = tick & ~link & is_out(csc1_r) & (cnt_r == val1_r);

    // Register select: one strobe beside one address.
    function sel;
        input strobe;
        input [7:0] a;
        input [7:0] want;
        begin
            sel = strobe & (a == want);
        end
    endfunction

    wire wr_tsc = sel(wr, addr, `TMB_A_TSC);
    wire wr_limh = sel(wr, addr, `TMB_A_LIMH);
    wire wr_liml = sel(wr, addr, `TMB_A_LIML);
    wire wr_c0sc = sel(wr, addr, `TMB_A_C0SC);
    wire wr_c0h = sel(wr, addr, `TMB_A_C0H);
    wire wr_c0l = sel(wr, addr, `TMB_A_C0L);
    wire wr_c1sc = sel(wr, addr, `TMB_A_C1SC);
    wire wr_c1h = sel(wr, addr, `TMB_A_C1H);
    wire wr_c1l = sel(wr, addr, `TMB_A_C1L);
    wire rd_cnth = sel(rd, addr, `TMB_A_CNTH);
    wire ch0_wr = wr_c0h | wr_c0l;
    wire ch1_wr = wr_c1h | wr_c1l;
    wire clr_cmd = wr_tsc & wdata[`TMB_B_CLR];

    // Prescaler; it holds while halted so a restart keeps its phase.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_r <= 6'h00;
        end else if (clr_cmd) begin
            pre_r <= 6'h00;
        end else if (!halt) begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // Counter; clear outranks wrap, and wrap outranks the tick.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= {CW{1'b0}};
        end else if (clr_cmd) begin
            cnt_r <= {CW{1'b0}};
        end else if (wrap_ev) begin
            cnt_r <= {CW{1'b0}};
        end else if (tick) begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // Timer status; hardware set of the wrap flag wins over a clear.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tsc_r <= `TMB_TSC_RST;
        end else begin
            if (wr_tsc) begin
                tsc_r <= {tsc_r[7] & wdata[7], wdata[6:5], 2'b00,
                    wdata[2:0]};
            end
            if (wrap_ev) begin
                tsc_r[`TMB_B_FLAG] <= 1'b1;
            end
        end
    end

    // Wrap limit, written one byte at a time.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lim_r <= `TMB_LIM_RST;
        end else begin
            if (wr_limh) begin
                lim_r[15:8] <= wdata;
            end
            if (wr_liml) begin
                lim_r[7:0] <= wdata;
            end
        end
    end

    // Channel 0 control; an event in the cycle of a clear keeps the flag.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csc0_r <= `TMB_CSC_RST;
        end else begin
            if (wr_c0sc) begin
                csc0_r <= {csc0_r[7] & wdata[7], wdata[6:0]};
            end
            if (cap0 || m0) begin
                csc0_r[`TMB_B_FLAG] <= 1'b1;
            end
        end
    end

    // Channel 1 control; it has no link bit, so that position reads 0.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csc1_r <= `TMB_CSC_RST;
        end else begin
            if (wr_c1sc) begin
                csc1_r <= {csc1_r[7] & wdata[7], wdata[6], 1'b0,
                    wdata[4:0]};
            end
            if (cap1 || m1) begin
                csc1_r[`TMB_B_FLAG] <= 1'b1;
            end
        end
    end

    // Channel values have no reset so their content survives it.
    always @(posedge clk) begin
        if (cap0) begin
            val0_r <= cap_val;
        end else if (wr_c0h) begin
            val0_r[15:8] <= wdata;
        end else if (wr_c0l) begin
            val0_r[7:0] <= wdata;
        end
    end

    // Channel 1 value, loaded the same way.
    always @(posedge clk) begin
        if (cap1) begin
            val1_r <= cap_val;
        end else if (wr_c1h) begin
            val1_r[15:8] <= wdata;
        end else if (wr_c1l) begin
            val1_r[7:0] <= wdata;
        end
    end

    // Active pair of a linked output; it changes only at wrap.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act1_r <= 1'b0;
        end else if (!link) begin
            act1_r <= 1'b0;
        end else if (wrap_ev && pend_r) begin
            act1_r <= pend_sel_r;
        end
    end

    // Last written pair, held until the next wrap hands it over.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_r <= 1'b0;
            pend_sel_r <= 1'b0;
        end else if (!link) begin
            pend_r <= 1'b0;
            pend_sel_r <= 1'b0;
        end else if (ch0_wr || ch1_wr) begin
            pend_r <= 1'b1;
            pend_sel_r <= ch1_wr;
        end else if (wrap_ev) begin
            pend_r <= 1'b0;
        end
    end

    // Pin 0 drive: compare first, then toggle on wrap for the same edge.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan0_pin_out <= 1'b0;
        end else begin
            if (m0 && wrap_ev && csc0_r[`TMB_B_TOV]) begin
                chan0_pin_out <= ~cmp_act(csc0_r, chan0_pin_out);
            end else if (m0) begin
                chan0_pin_out <= cmp_act(csc0_r, chan0_pin_out);
            end else if (wrap_ev && is_out(csc0_r) && csc0_r[`TMB_B_TOV]) begin
                chan0_pin_out <= ~chan0_pin_out;
            end
        end
    end

    // Pin 1 drive; it stands still while the channels are linked.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan1_pin_out <= 1'b0;
        end else begin
            if (m1 && wrap_ev && csc1_r[`TMB_B_TOV]) begin
                chan1_pin_out <= ~cmp_act(csc1_r, chan1_pin_out);
            end else if (m1) begin
                chan1_pin_out <= cmp_act(csc1_r, chan1_pin_out);
            end else if (wrap_ev && !link && is_out(csc1_r) &&
                csc1_r[`TMB_B_TOV]) begin
                chan1_pin_out <= ~chan1_pin_out;
            end
        end
    end

    // Pin enable is active low; a released pin belongs to general I/O.
    assign chan0_pin_oe_n = ~(is_out(csc0_r) &
        (csc0_r[`TMB_B_ELSB] | csc0_r[`TMB_B_ELSA]));
    assign chan1_pin_oe_n = link | ~(is_out(csc1_r) &
        (csc1_r[`TMB_B_ELSB] | csc1_r[`TMB_B_ELSA]));

    assign wrap_irq = tsc_r[`TMB_B_FLAG] & tsc_r[`TMB_B_IE];
    assign chan0_irq = csc0_r[`TMB_B_FLAG] & csc0_r[`TMB_B_IE];
    assign chan1_irq = ~link & csc1_r[`TMB_B_FLAG] & csc1_r[`TMB_B_IE];

    // Reading the high count byte freezes the low byte so a 16-bit read
    // stays coherent; the counter itself keeps running.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_lo_latch_r <= 8'h00;
        end else if (rd_cnth) begin
            cnt_lo_latch_r <= cnt_r[7:0];
        end
    end

    // Read data stand for one cycle only and are zero otherwise.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            if (rd) begin
                case (addr)
                    `TMB_A_TSC: rdata <= tsc_r;
                    `TMB_A_CNTH: rdata <= cnt_r[15:8];
                    `TMB_A_CNTL: rdata <= cnt_lo_latch_r;
                    `TMB_A_LIMH: rdata <= lim_r[15:8];
                    `TMB_A_LIML: rdata <= lim_r[7:0];
                    `TMB_A_C0SC: rdata <= csc0_r;
                    `TMB_A_C0H: rdata <= val0_r[15:8];
                    `TMB_A_C0L: rdata <= val0_r[7:0];
                    `TMB_A_C1SC: rdata <= csc1_r;
                    `TMB_A_C1H: rdata <= val1_r[15:8];
                    `TMB_A_C1L: rdata <= val1_r[7:0];
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule // tmb_timer

//--- tmb_defs.vh
// Constants for the two-channel capture/compare timer: register offsets,
// field positions and timing figures. Included by the timer module only.
// Notes on behaviour
// - A 16-bit up-counter is the shared time base, free or modulo.
// - The wrap limit comes from the programmable 16-bit limit register pair.
// - Reading the count never disturbs the counting sequence.
// - Prescale select picks one of seven bus-clock taps or the pin clock.
// - The external count clock may run up to 4 MHz.
// - Each channel is independently capture or compare.
// - Capture triggers on rising, falling or either edge, per select bits.
// - An active capture edge copies the counter into the channel value.
// - Captured value is the counter at the synchronised edge plus one.
// - Capture happens regardless of the flag and overwrites the old value.
// - A capture sets the channel flag; enable gates the interrupt request.
// - Reset leaves the channel value registers untouched.
// - A compare match sets, clears or toggles the channel pin.
// - A compare match sets the channel flag, which may raise an interrupt.
// - Unbuffered writes replace the compare value at once.
// - Channel 0 link select joins both channels into one output on pin 0.
// - Channel 0 values rule first; a channel 1 write takes over at wrap.
// - At each wrap, the most recently written pair takes control.
// - While linked, channel 1 control is ignored and its pin released.
// - A driven channel pin toggles on wrap when its toggle bit is set.
// - Wrap to zero after the limit sets the wrap flag, enable gates it.
// - Counter clear resets counter and prescaler; halt stops counting.
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH
`define TMB_A_TSC 8'h40
`define TMB_A_CNTH 8'h41
`define TMB_A_CNTL 8'h42
`define TMB_A_LIMH 8'h43
`define TMB_A_LIML 8'h44
`define TMB_A_C0SC 8'h45
`define TMB_A_C0H 8'h46
`define TMB_A_C0L 8'h47
`define TMB_A_C1SC 8'h48
`define TMB_A_C1H 8'h49
`define TMB_A_C1L 8'h4a
`define TMB_B_FLAG 7
`define TMB_B_IE 6
`define TMB_B_HALT 5
`define TMB_B_CLR 4
`define TMB_B_LINK 5
`define TMB_B_MSA 4
`define TMB_B_ELSB 3
`define TMB_B_ELSA 2
`define TMB_B_TOV 1
`define TMB_B_MAX 0
`define TMB_TSC_RST 8'h20
`define TMB_CSC_RST 8'h00
`define TMB_LIM_RST 16'hffff
`define TMB_PS_EXT 3'h7
`define TMB_SYNC_DELAY 16'h0002
`define TMB_EXT_MHZ 4
`define TMB_BUS_MHZ 40
`endif

//--- tmb_checker.sv
// Assertions on the timer's register port, pin enables and requests.
// Assumes it is bound to the timer and sees only its ports.
`timescale 1ns/1ps
module tmb_checker (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Register port.
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // Pin enables and requests.
    input wire chan0_pin_oe_n,
    input wire chan1_pin_oe_n,
    input wire wrap_irq,
    input wire chan0_irq,
    input wire chan1_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    read_idle_zero_a:
        assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("Read data not zero outside a read.");
    unmapped_read_a:
        assert property (rd && (addr < 8'h40 || addr > 8'h4a)
            |=> rdata == 8'h00) else $error("Unmapped read not zero.");
    limit_readback_a:
        assert property ((wr && addr == 8'h43) ##1 !wr
            ##1 (rd && addr == 8'h43) |=> rdata == $past(wdata, 3))
        else $error("Limit high byte does not read back.");
    clear_count_a:
        assert property ((wr && addr == 8'h40 && wdata[5:4] == 2'b11)
            ##2 (rd && addr == 8'h41) |=> rdata == 8'h00)
        else $error("Counter not cleared.");
    link_release_a:
        assert property (wr && addr == 8'h45 && wdata[5]
            |=> chan1_pin_oe_n) else $error("Channel 1 pin not released.");
    compare_drive_a:
        assert property (wr && addr == 8'h45 && wdata[5:4] == 2'b01
            && wdata[3:2] != 2'b00 |=> !chan0_pin_oe_n)
        else $error("Compare channel 0 does not drive its pin.");
    wrap_gate_a:
        assert property (wr && addr == 8'h40 && !wdata[6] |=> !wrap_irq)
        else $error("Wrap request not gated by its enable.");
    chan0_gate_a:
        assert property (wr && addr == 8'h45 && !wdata[6] |=> !chan0_irq)
        else $error("Channel 0 request not gated.");
    chan1_gate_a:
        assert property (wr && addr == 8'h48 && !wdata[6] |=> !chan1_irq)
        else $error("Channel 1 request not gated.");
endmodule // tmb_checker

//--- tmb_far.sv
// Far-side model: capture inputs, external count clock and pin wires.
// Assumes the bench sets the outside levels of the capture inputs.
`timescale 1ns/1ps
module tmb_far (
    // Controls from the bench.
    input wire ext_en,
    input wire [1:0] lvl,
    // Timer pins.
    input wire chan0_pin_out,
    input wire chan1_pin_out,
    input wire chan0_pin_oe_n,
    input wire chan1_pin_oe_n,
    output reg ext_count_clock_pin,
    output wire chan0_pin_in,
    output wire chan1_pin_in
);
    // A driven pin reads back the timer's own level.
    assign chan0_pin_in = chan0_pin_oe_n ? lvl[0] : chan0_pin_out;
    assign chan1_pin_in = chan1_pin_oe_n ? lvl[1] : chan1_pin_out;
    // Runs at the fastest allowed rate, and stands still when not enabled.
    initial begin
        ext_count_clock_pin = 1'b0;
        forever begin
            #125;
            ext_count_clock_pin = ext_en & ~ext_count_clock_pin;
        end
    end
endmodule // tmb_far

//--- tb_tmb_timer.sv
// Self-checking bench for the two-channel capture/compare timer.
// Assumes the far-side model and the checker compile before it.
`timescale 1ns/1ps
module tb_tmb_timer;
    reg clk, resetn, wr, rd, ext_en;
    reg [7:0] addr, wdata, d, h;
    reg [1:0] lvl;
    reg [15:0] c1, c2;
    wire [7:0] rdata;
    wire p0_in, p1_in, p0_out, p1_out, oe0_n, oe1_n, ext_pin;
    wire wrap_irq, chan0_irq, chan1_irq;
    integer mismatches, tests_run, cyc, n, i;
    tmb_timer i_tmb_timer (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_count_clock_pin(ext_pin), .chan0_pin_in(p0_in),
        .chan1_pin_in(p1_in), .chan0_pin_out(p0_out),
        .chan1_pin_out(p1_out), .chan0_pin_oe_n(oe0_n),
        .chan1_pin_oe_n(oe1_n), .wrap_irq(wrap_irq),
        .chan0_irq(chan0_irq), .chan1_irq(chan1_irq));
    tmb_far i_tmb_far (.ext_en(ext_en), .lvl(lvl), .chan0_pin_out(p0_out),
        .chan1_pin_out(p1_out), .chan0_pin_oe_n(oe0_n),
        .chan1_pin_oe_n(oe1_n), .ext_count_clock_pin(ext_pin),
        .chan0_pin_in(p0_in), .chan1_pin_in(p1_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input string what, input [15:0] seen, input [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // The low byte comes from the latch loaded by the high-byte read.
    task rd_cnt(output [15:0] v);
        rd_reg(8'h41);
        h = d;
        rd_reg(8'h42);
        v = {h, d};
    endtask
    task go(input [7:0] tsc);
        wr_reg(8'h40, 8'h30);
        wr_reg(8'h40, tsc);
    endtask
    task gap(output integer k);
        reg s;
        s = p0_out;
        k = 0;
        do begin
            @(posedge clk);
            #1 k = k + 1;
        end while (p0_out === s && k < 300);
    endtask
    task t_reset;
        rd_reg(8'h40);
        check("status", d, 8'h20);
        rd_reg(8'h48);
        check("chan1 control", d, 8'h00);
        rd_reg(8'h50);
        check("unmapped", d, 8'h00);
        wr_reg(8'h43, 8'h12);
        rd_reg(8'h43);
        check("limit high", d, 8'h12);
        wr_reg(8'h41, 8'h55);
        wr_reg(8'h40, 8'h30);
        rd_cnt(c1);
        check("count", c1, 16'h0000);
        wr_reg(8'h43, 8'hff);
    endtask
    task t_prescale;
        for (i = 0; i < 8; i = i + 1) begin
            ext_en <= (i == 7);
            go(i);
            repeat (640) @(posedge clk);
            wr_reg(8'h40, 8'h20 | i);
            rd_cnt(c1);
            repeat (20) @(posedge clk);
            rd_cnt(c2);
            check("halted count", c2, c1);
            n = c1 - ((i == 7) ? 64 : (640 >> i));
            check("count rate", n >= -3 && n <= 3, 1'b1);
        end
        ext_en <= 1'b0;
    endtask
    task t_wrap;
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h44, 8'h09);
        go(8'h00);
        repeat (25) @(posedge clk);
        wr_reg(8'h40, 8'ha0);
        rd_reg(8'h40);
        check("wrap flag", d[7], 1'b1);
        rd_cnt(c1);
        check("count bound", c1 <= 9, 1'b1);
        wr_reg(8'h40, 8'he0);
        check("wrap request", wrap_irq, 1'b1);
        wr_reg(8'h40, 8'h60);
        check("wrap cleared", wrap_irq, 1'b0);
    endtask
    task t_capture;
        wr_reg(8'h43, 8'hff);
        wr_reg(8'h44, 8'hff);
        go(8'h00);
        for (i = 1; i < 4; i = i + 1) begin
            wr_reg(8'h48, i << 2);
            lvl[1] <= 1'b1;
            repeat (8) @(posedge clk);
            rd_reg(8'h48);
            check("rise capture", d[7], i % 2);
            wr_reg(8'h48, i << 2);
            lvl[1] <= 1'b0;
            repeat (8) @(posedge clk);
            rd_reg(8'h48);
            check("fall capture", d[7], i / 2);
        end
        wr_reg(8'h48, 8'h44);
        @(posedge clk);
        lvl[1] <= 1'b1;
        n = cyc;
        repeat (8) @(posedge clk);
        rd_reg(8'h48);
        check("capture flag", d[7], 1'b1);
        check("capture request", chan1_irq, 1'b1);
        rd_reg(8'h49);
        h = d;
        rd_reg(8'h4a);
        c1 = {h, d};
        lvl[1] <= 1'b0;
        while (cyc < n + 100) @(posedge clk);
        lvl[1] <= 1'b1;
        repeat (8) @(posedge clk);
        rd_reg(8'h49);
        h = d;
        rd_reg(8'h4a);
        c2 = {h, d};
        check("capture spacing", c2 - c1, 16'h0064);
    endtask
    task t_compare;
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h44, 8'h0f);
        wr_reg(8'h46, 8'h00);
        wr_reg(8'h47, 8'h05);
        wr_reg(8'h45, 8'h5c);
        go(8'h00);
        repeat (40) @(posedge clk);
        check("set on match", p0_out, 1'b1);
        check("match request", chan0_irq, 1'b1);
        check("pin driven", oe0_n, 1'b0);
        wr_reg(8'h45, 8'h1e);
        gap(n);
        if (p0_out === 1'b1)
            gap(n);
        gap(n);
        check("low span", n, 6);
        gap(n);
        check("high span", n, 10);
    endtask
    // Only the idle pair is rewritten, so the handover is exact.
    task t_link;
        wr_reg(8'h47, 8'h03);
        wr_reg(8'h48, 8'h5c);
        wr_reg(8'h45, 8'h24);
        go(8'h00);
        gap(n);
        gap(n);
        check("linked period", n, 16);
        check("chan1 released", oe1_n, 1'b1);
        wr_reg(8'h49, 8'h00);
        wr_reg(8'h4a, 8'h01);
        gap(n);
        // The two writes use four cycles of the span that gap measures.
        check("chan1 takes over", n + 4, 14);
        wr_reg(8'h46, 8'h00);
        wr_reg(8'h47, 8'h05);
        gap(n);
        check("last written rules", n + 4, 20);
    endtask
    initial begin
        resetn = 1'b0;
        {wr, rd, ext_en, lvl, addr, wdata} = 0;
        {mismatches, tests_run, cyc} = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_prescale;
        t_wrap;
        t_capture;
        t_compare;
        t_link;
        report_and_stop;
    end
endmodule // tb_tmb_timer
bind tmb_timer tmb_checker i_tmb_checker (.clk(clk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .chan0_pin_oe_n(chan0_pin_oe_n), .chan1_pin_oe_n(chan1_pin_oe_n),
    .wrap_irq(wrap_irq), .chan0_irq(chan0_irq), .chan1_irq(chan1_irq));
